// ### src/mains_range_selector.sv
// Top of the automatic mains range selector: range control and gate drive
`timescale 1ns/100ps
`include "range_sel_consts.svh"

// Operation in short: after reset the block waits a fixed start-up
// time in bridge range with the triac off. In failsafe mode it then
// stays in bridge range until the next reset. In reactive mode a
// filtered low-range indication starts a validation count of mains
// periods; only when the low range holds for the whole count does
// the block enter doubler range and pulse the triac gate. A filtered
// high-range indication drops the gate at once and returns to bridge.
// All comparator and zero-cross inputs pass through the filter first,
// so every decision below works on clean, synchronous levels and a
// single tick per mains period.

// Function
// - Failsafe mode locks bridge range until reset.
// - Reactive mode follows sensed range both ways.
// - Rise to high range stops gate promptly.
// - Fall confirmed over 8 periods first.
// - After reset, 8 low periods before doubler.
// - Start in bridge, wait 250 ms.
// - Leave above upper; low below upper minus hysteresis.
// - Two separated thresholds avoid small-swing toggling.
// - Triac on in doubler, off in bridge.
// - Count mains periods, works 50/60 Hz.
// - Gate drive is 10 percent pulse train.
// - Filter out excursions under 200 us.
module mains_range_selector
  import range_sel_pkg::*;
#(
  parameter int STARTUP_CYCLES = `STARTUP_CYCLES,
  parameter int FILTER_CYCLES = `FILTER_CYCLES,
  parameter int GATE_PERIOD = `GATE_PERIOD_CYCLES,
  parameter int GATE_ON = `GATE_ON_CYCLES,
  parameter int VALIDATE_PERIODS = `VALIDATE_PERIODS
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic ABOVE_UPPER,
  input wire logic BELOW_LOWER,
  input wire logic ZERO_CROSS,
  input wire logic MODE_REACTIVE,
  output logic TRIAC_GATE,
  output logic DOUBLER_ACTIVE
);
  localparam int SW = $clog2(STARTUP_CYCLES + 1);
  localparam int GW = $clog2(GATE_PERIOD + 1);
  localparam int VW = $clog2(VALIDATE_PERIODS + 1);

  // Counters must be able to reach their terminal counts; the gate
  // pulse needs at least one low cycle or the triac would see a level
  if (STARTUP_CYCLES < 1) begin : g_bad_startup
    $error("STARTUP_CYCLES must be positive");
  end
  if (VALIDATE_PERIODS < 1) begin : g_bad_validate
    $error("VALIDATE_PERIODS must be positive");
  end
  if (GATE_ON < 1) begin : g_bad_gate_on
    $error("GATE_ON must be at least 1");
  end
  if (GATE_ON >= GATE_PERIOD) begin : g_bad_gate_period
    $error("GATE_ON must stay below GATE_PERIOD");
  end

  // Filtered indications; the control logic never sees a raw pin, so
  // a spike shorter than the filter window cannot move the range
  sense_if sense ();

  sense_filter #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_filter (
    .clk(CLK),
    .reset(RESET),
    .above_raw(ABOVE_UPPER),
    .below_raw(BELOW_LOWER),
    .zero_raw(ZERO_CROSS),
    .sense(sense.filt)
  );

  // Range state with its start-up and validation counters
  range_state_type state;
  range_state_type next_state;
  logic [SW-1:0] start_cnt;
  logic [SW-1:0] next_start_cnt;
  logic [VW-1:0] period_cnt;
  logic [VW-1:0] next_period_cnt;
  // Position inside the gate pulse period
  logic [GW-1:0] gate_cnt;
  logic [GW-1:0] next_gate_cnt;
  // Mode strap as captured after reset
  logic mode_reactive;
  logic next_mode_reactive;
  logic mode_caught;
  logic next_mode_caught;
  // Gate request and next registered gate level
  logic triac_on;
  logic next_gate;

  // Mode pin is taken once after reset release, so a floating change
  // later cannot unlock the failsafe latch. The cost is that a board
  // which changes the strap needs a reset before the new mode applies.
  always_comb begin
    next_mode_caught = 1'b1;
    next_mode_reactive = mode_reactive;
    if (!mode_caught) begin
      next_mode_reactive = MODE_REACTIVE;
    end
  end

  // Mode capture registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      mode_reactive <= 1'b0;
      mode_caught <= 1'b0;
    end else begin
      mode_reactive <= next_mode_reactive;
      mode_caught <= next_mode_caught;
    end
  end

  // Range decision; only the upper flag ends doubler and only the
  // lower (hysteresis) flag starts validation, so small swings between
  // the two thresholds change nothing.
  always_comb begin
    next_state = state;
    next_start_cnt = start_cnt;
    next_period_cnt = period_cnt;
    case (state)
      ST_STARTUP: begin
        // Fixed delay lets the supply settle before any range change
        if (start_cnt == SW'(STARTUP_CYCLES - 1)) begin
          next_state = ST_BRIDGE;
        end else begin
          next_start_cnt = start_cnt + SW'(1);
        end
      end
      ST_BRIDGE: begin
        // Failsafe locks here; reactive mode looks for the low range
        next_period_cnt = '0;
        if (!mode_reactive) begin
          next_state = ST_LOCKED;
        end else if (sense.below_lower && !sense.above_upper) begin
          next_state = ST_VALIDATE;
        end
      end
      ST_VALIDATE: begin
        // Any return of the high range or loss of the low flag
        // restarts validation from zero periods
        if (sense.above_upper || !sense.below_lower) begin
          next_state = ST_BRIDGE;
          next_period_cnt = '0;
        end else if (sense.period_tick) begin
          if (period_cnt == VW'(VALIDATE_PERIODS - 1)) begin
            next_state = ST_DOUBLER;
          end else begin
            next_period_cnt = period_cnt + VW'(1);
          end
        end
      end
      ST_DOUBLER: begin
        // Only the upper flag ends doubler; the band below it holds
        if (sense.above_upper) begin
          next_state = ST_BRIDGE;
        end
      end
      ST_LOCKED: begin
        // Left only through reset
        next_state = ST_LOCKED;
      end
      default: begin
        // An illegal code falls back to the safe start
        next_state = ST_STARTUP;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= ST_STARTUP;
      start_cnt <= '0;
      period_cnt <= '0;
    end else begin
      state <= next_state;
      start_cnt <= next_start_cnt;
      period_cnt <= next_period_cnt;
    end
  end

  // Pulse train cuts gate power; counter parked while triac is off.
  // The request also drops on the filtered upper flag itself, so the
  // gate stops on the same clock edge as the state register leaves doubler.
  // Each new doubler spell starts with a full high pulse because the
  // counter always restarts from zero.
  assign triac_on = (state == ST_DOUBLER) && !sense.above_upper;
  always_comb begin
    next_gate_cnt = '0;
    next_gate = `TRIAC_RESET;
    if (triac_on) begin
      next_gate = (gate_cnt < GW'(GATE_ON));
      if (gate_cnt != GW'(GATE_PERIOD - 1)) begin
        next_gate_cnt = gate_cnt + GW'(1);
      end
    end
  end

  // Gate registers; outputs come straight from flops, free of glitches
  always_ff @(posedge CLK) begin
    if (RESET) begin
      gate_cnt <= '0;
      TRIAC_GATE <= `TRIAC_RESET;
      DOUBLER_ACTIVE <= 1'b0;
    end else begin
      gate_cnt <= next_gate_cnt;
      TRIAC_GATE <= next_gate;
      DOUBLER_ACTIVE <= triac_on;
    end
  end
endmodule

// ### src/range_sel_consts.svh
// Constants for the mains range selector: timing counts and reset values
`ifndef RANGE_SEL_CONSTS_SVH
`define RANGE_SEL_CONSTS_SVH

`define CLK_HZ 25000000
`define STARTUP_DELAY_MS 250
`define STARTUP_CYCLES ((`CLK_HZ / 1000) * `STARTUP_DELAY_MS)
`define FILTER_US 200
`define FILTER_CYCLES (((`CLK_HZ / 1000000) * `FILTER_US) + 1)
`define GATE_PERIOD_NS 23000
`define GATE_PERIOD_CYCLES (`GATE_PERIOD_NS / 40)
`define GATE_DUTY_PCT 10
`define GATE_ON_CYCLES ((`GATE_PERIOD_CYCLES * `GATE_DUTY_PCT) / 100)
`define VALIDATE_PERIODS 8
`define TRIAC_RESET 1'b0

`endif

// ### src/range_sel_pkg.sv
// Types shared by the mains range selector modules
package range_sel_pkg;
  typedef enum logic [4:0] {
    ST_STARTUP = 5'h01,
    ST_BRIDGE = 5'h02,
    ST_VALIDATE = 5'h04,
    ST_DOUBLER = 5'h08,
    ST_LOCKED = 5'h10
  } range_state_type;
endpackage

// ### src/sense_if.sv
// Filtered mains sense indications passed from the input filter
`timescale 1ns/100ps
interface sense_if;
  logic above_upper;
  logic below_lower;
  logic period_tick;
  modport filt (output above_upper, output below_lower, output period_tick);
  modport ctrl (input above_upper, input below_lower, input period_tick);
endinterface

// ### src/sense_filter.sv
// Synchroniser and spike filter for the comparator and zero-cross inputs
`timescale 1ns/100ps
`include "range_sel_consts.svh"
module sense_filter
  import range_sel_pkg::*;
#(
  parameter int FILTER_CYCLES = `FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic above_raw,
  input wire logic below_raw,
  input wire logic zero_raw,
  sense_if.filt sense
);
  localparam int CW = $clog2(FILTER_CYCLES + 1);
  // A window of one cycle would pass every spike straight through
  if (FILTER_CYCLES < 2) begin : g_bad_filter
    $error("FILTER_CYCLES must be at least 2");
  end

  logic [2:0] meta;
  logic [2:0] sync;
  logic [2:0] stable;
  logic [2:0] next_stable;
  logic [CW-1:0] cnt [3];
  logic [CW-1:0] next_cnt [3];
  logic zero_prev;
  logic next_tick;

  // Per input: a new level must hold for the full window before it counts
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_filt
      always_comb begin
        next_stable[i] = stable[i];
        next_cnt[i] = '0;
        if (sync[i] != stable[i]) begin
          if (cnt[i] == CW'(FILTER_CYCLES - 1)) begin
            next_stable[i] = sync[i];
          end else begin
            next_cnt[i] = cnt[i] + CW'(1);
          end
        end
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          cnt[i] <= '0;
        end else begin
          cnt[i] <= next_cnt[i];
        end
      end
    end
  endgenerate

  // Rising edge of filtered zero-cross gives one tick per mains period
  always_comb begin
    next_tick = stable[2] & ~zero_prev;
  end

  // Two-flop synchroniser, filter state and tick register
  always_ff @(posedge clk) begin
    if (reset) begin
      meta <= 3'h0;
      sync <= 3'h0;
      stable <= 3'h0;
      zero_prev <= 1'b0;
      sense.period_tick <= 1'b0;
    end else begin
      meta <= {zero_raw, below_raw, above_raw};
      sync <= meta;
      stable <= next_stable;
      zero_prev <= stable[2];
      sense.period_tick <= next_tick;
    end
  end

  assign sense.above_upper = stable[0];
  assign sense.below_lower = stable[1];
endmodule

// ### verif/range_sel_checker.sv
// Port checker for the mains range selector
`timescale 1ns/100ps
module range_sel_checker #(
  parameter int STARTUP_CYCLES = 20,
  parameter int GATE_PERIOD = 10,
  parameter int GATE_ON = 1,
  parameter int VALIDATE_PERIODS = 8
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic ABOVE_UPPER,
  input wire logic BELOW_LOWER,
  input wire logic ZERO_CROSS,
  input wire logic MODE_REACTIVE,
  input wire logic TRIAC_GATE,
  input wire logic DOUBLER_ACTIVE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  int st, ph, zc, ab;
  logic rd, mode, zd;
  // Helpers st, ab and zc saturate so long runs never wrap into false passes; ph wraps each gate period
  always_ff @(posedge CLK) begin
    rd <= RESET;
    zd <= ZERO_CROSS;
    if (RESET) mode <= 1'b1;
    else if (rd) mode <= MODE_REACTIVE;
    st <= RESET ? 0 : (st < STARTUP_CYCLES ? st + 1 : st);
    ph <= (RESET || !DOUBLER_ACTIVE) ? 0 : (ph + 1) % GATE_PERIOD;
    ab <= (RESET || ABOVE_UPPER) ? 0 : (ab < 99 ? ab + 1 : ab);
    if (RESET || ABOVE_UPPER || !BELOW_LOWER) zc <= 0;
    else if (ZERO_CROSS && !zd && zc < 99) zc <= zc + 1;
  end
  a_reset_clear: assert property (disable iff (1'b0)
    RESET |=> !TRIAC_GATE && !DOUBLER_ACTIVE) else $error("reset");
  a_startup_hold: assert property (
    st < STARTUP_CYCLES |-> !DOUBLER_ACTIVE) else $error("early");
  a_validate_count: assert property (
    $rose(DOUBLER_ACTIVE) |-> zc >= VALIDATE_PERIODS) else $error("count");
  a_failsafe_lock: assert property (
    !mode |-> !DOUBLER_ACTIVE) else $error("lock");
  a_above_drop: assert property (
    ABOVE_UPPER [*8] |-> ##[0:4] !DOUBLER_ACTIVE) else $error("drop");
  a_leave_cause: assert property (
    $fell(DOUBLER_ACTIVE) |-> ab < 16) else $error("leave");
  a_gate_pulse: assert property (
    DOUBLER_ACTIVE |-> TRIAC_GATE == (ph < GATE_ON)) else $error("pulse");
  a_gate_bridge: assert property (
    !DOUBLER_ACTIVE |-> !TRIAC_GATE) else $error("gate");
  cover property ($rose(DOUBLER_ACTIVE));
  cover property ($fell(DOUBLER_ACTIVE));
  cover property (!mode && st == STARTUP_CYCLES);
endmodule

// ### verif/mains_sense_model.sv
// Mains model: range comparators and a free running zero-cross wave
`timescale 1ns/100ps
module mains_sense_model (
  input wire logic clk,
  input wire logic [1:0] level,
  input wire logic spike,
  input wire logic [31:0] half,
  output logic above,
  output logic below,
  output logic zero
);
  int n = 0;
  initial zero = 1'b0;
  // Mains never stops, so the wave runs in every state
  always @(negedge clk) begin
    n <= (n >= int'(half) - 1) ? 0 : n + 1;
    if (n >= int'(half) - 1) zero <= !zero;
  end
  // Level 0 low range, 1 hysteresis band, 2 high range
  assign above = spike || level == 2'h2;
  assign below = level == 2'h0;
endmodule

// ### verif/mains_range_selector_tb_top.sv
// Testbench for the mains range selector
`timescale 1ns/100ps
module mains_range_selector_tb_top;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic MODE_REACTIVE = 1'b1;
  logic spike = 1'b0;
  logic [1:0] level = 2'h2;
  logic ABOVE_UPPER, BELOW_LOWER, ZERO_CROSS, TRIAC_GATE, DOUBLER_ACTIVE;
  int half = 30;
  int mismatches = 0;
  int compares = 0;
  initial forever #20 CLK = !CLK;
  mains_range_selector #(.STARTUP_CYCLES(20), .FILTER_CYCLES(4),
    .GATE_PERIOD(10), .GATE_ON(1), .VALIDATE_PERIODS(8))
  i_mains_range_selector (.CLK(CLK), .RESET(RESET),
    .ABOVE_UPPER(ABOVE_UPPER), .BELOW_LOWER(BELOW_LOWER),
    .ZERO_CROSS(ZERO_CROSS), .MODE_REACTIVE(MODE_REACTIVE),
    .TRIAC_GATE(TRIAC_GATE), .DOUBLER_ACTIVE(DOUBLER_ACTIVE));
  mains_sense_model i_mains_sense_model (.clk(CLK), .level(level),
    .spike(spike), .half(half), .above(ABOVE_UPPER),
    .below(BELOW_LOWER), .zero(ZERO_CROSS));
  task check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %b", $time, got);
    end
  endtask
  task complete_run;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Doubler flag must keep one value for n cycles
  task hold(input logic exp, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(negedge CLK);
      if (DOUBLER_ACTIVE !== exp) bad = 1'b1;
    end
    check_bit(bad, 1'b0);
  endtask
  // Bounded wait for the doubler flag to reach a value
  task wait_for(input logic exp, input int n);
    for (int i = 0; i < n && DOUBLER_ACTIVE !== exp; i++) @(negedge CLK);
    check_bit(DOUBLER_ACTIVE, exp);
  endtask
  task start(input logic mode, input logic [1:0] lv);
    @(negedge CLK);
    RESET = 1'b1;
    MODE_REACTIVE = mode;
    level = lv;
    repeat (12) @(negedge CLK);
    RESET = 1'b0;
    check_bit(DOUBLER_ACTIVE, 1'b0);
  endtask
  task t_power_on;
    int cnt;
    start(1'b1, 2'h0);
    hold(1'b0, 20 + 14 * half);
    wait_for(1'b1, 8 * half);
    cnt = 0;
    repeat (100) begin
      @(negedge CLK);
      cnt += TRIAC_GATE;
    end
    check_bit(cnt == 10, 1'b1);
  endtask
  task t_ranges;
    level = 2'h2;
    wait_for(1'b0, 2 * half);
    check_bit(TRIAC_GATE, 1'b0);
    level = 2'h1;
    hold(1'b0, 20 * half);
    half = 25;
    level = 2'h0;
    repeat (8 * half) @(negedge CLK);
    level = 2'h1;
    repeat (8) @(negedge CLK);
    level = 2'h0;
    hold(1'b0, 12 * half);
    wait_for(1'b1, 6 * half);
    level = 2'h1;
    hold(1'b1, 20 * half);
    repeat (5) begin
      spike = 1'b1;
      repeat (2) @(negedge CLK);
      spike = 1'b0;
      repeat (20) @(negedge CLK);
    end
    check_bit(DOUBLER_ACTIVE, 1'b1);
  endtask
  task t_failsafe;
    start(1'b0, 2'h0);
    hold(1'b0, 20 + 20 * half);
    level = 2'h2;
    repeat (4 * half) @(negedge CLK);
    level = 2'h0;
    hold(1'b0, 20 * half);
  endtask
  initial begin
    t_power_on;
    t_ranges;
    t_failsafe;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    complete_run;
  end
endmodule
bind mains_range_selector range_sel_checker #(
  .STARTUP_CYCLES(STARTUP_CYCLES), .GATE_PERIOD(GATE_PERIOD),
  .GATE_ON(GATE_ON), .VALIDATE_PERIODS(VALIDATE_PERIODS))
i_range_sel_checker (.CLK(CLK), .RESET(RESET),
  .ABOVE_UPPER(ABOVE_UPPER), .BELOW_LOWER(BELOW_LOWER),
  .ZERO_CROSS(ZERO_CROSS), .MODE_REACTIVE(MODE_REACTIVE),
  .TRIAC_GATE(TRIAC_GATE), .DOUBLER_ACTIVE(DOUBLER_ACTIVE));
